// ==== logic/dtl_defs.svh ====
// Purpose: Offsets, bit positions and reset values for the trim loader
// Assumes: Byte-wide registers, one per aligned 32-bit word
// Notes: Printed offsets are register indexes, byte address is index * 4
`ifndef DTL_DEFS_SVH
`define DTL_DEFS_SVH

`define DTL_IDX_TRIM_PORT 5'h1A
`define DTL_IDX_RESET 5'h1B
`define DTL_IDX_UNUSED_LO 5'h1C
`define DTL_IDX_UNUSED_HI 5'h1E
`define DTL_IDX_MODEL 5'h1F
`define DTL_IDX_TRIM0 5'h10
`define DTL_IDX_TRIM1 5'h11
`define DTL_BIT_SDATA 7
`define DTL_BIT_SCLK 0
`define DTL_BIT_FIFO_CLR 0
`define DTL_BIT_DIO_CLR 2
`define DTL_BIT_DAC_ZERO 3
`define DTL_BIT_GLOBAL 4
`define DTL_ENABLE_CODE 8'h80
`define DTL_END_CODE 8'h00
`define DTL_TRIM_RESET 8'h80
`define DTL_MODEL_VALUE 8'h01
`define DTL_ADDR_BITS 4'h2
`define DTL_FRAME_BITS 4'hA

`endif

// ==== logic/dtl_pkg.sv ====
// Purpose: Types shared by the trim loader
// Assumes: No constants; dtl_defs.svh is not included here
// Notes: Types only
package dtl_pkg;

    typedef enum logic [1:0] {
        DTL_IDLE = 2'b00,
        DTL_SHIFT = 2'b01,
        DTL_WAIT_END = 2'b10
    } dtl_state_e;

    typedef struct packed {
        logic sample_queue_clear;
        logic parallel_port_clear;
        logic analog_out_zero;
        logic global_clear;
    } dtl_clear_s;

    typedef logic [7:0] dtl_trim_t;

endpackage

// ==== logic/dtl_trim_regs.sv ====
// Purpose: Trim potentiometer serial loader, reset register, model register
// Assumes: Classic Wishbone slave, 32-bit data, one clock, sync reset
// Notes: Reads answer after one wait cycle; ack is registered
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "dtl_defs.svh"

module dtl_trim_regs #(
    parameter int NUM_POTS = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Trim and clear outputs
    output dtl_pkg::dtl_trim_t trim_gain_o [NUM_POTS],
    output dtl_pkg::dtl_clear_s clear_o,
    output logic config_default_o
);
    import dtl_pkg::*;

    dtl_state_e state;
    logic prev_sclk;
    logic [3:0] bit_cnt;
    logic [9:0] shreg;
    dtl_trim_t trim [NUM_POTS];
    logic req;
    logic wr_lane0;
    logic [4:0] idx;
    logic port_wr;
    logic rst_wr;
    logic sclk_bit;
    logic sdata_bit;
    logic sclk_rise;
    logic [7:0] wbyte;

    // Byte address bits 1:0 are ignored; registers sit on word boundaries
    assign idx = adr_i[6:2];
    assign req = cyc_i && stb_i && !ack_o;
    assign wr_lane0 = req && we_i && sel_i[0] && !adr_i[7];
    assign wbyte = dat_i[7:0];
    assign port_wr = wr_lane0 && (idx == `DTL_IDX_TRIM_PORT);
    assign rst_wr = wr_lane0 && (idx == `DTL_IDX_RESET);
    assign sclk_bit = wbyte[`DTL_BIT_SCLK];
    assign sdata_bit = wbyte[`DTL_BIT_SDATA];
    // Rising edge of the clock bit; the line idles low between writes
    assign sclk_rise = port_wr && sclk_bit && !prev_sclk;

    // Bus answer: one ack per request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Read mux; unused and write-only offsets read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            dat_o <= 32'h0000_0000;
            if (!adr_i[7]) begin
                case (idx)
                    `DTL_IDX_MODEL: begin
                        dat_o[7:0] <= `DTL_MODEL_VALUE;
                    end
                    `DTL_IDX_TRIM0: begin
                        dat_o[7:0] <= trim[0];
                    end
                    `DTL_IDX_TRIM1: begin
                        dat_o[7:0] <= trim[NUM_POTS-1];
                    end
                    default: begin
                        dat_o[7:0] <= 8'h00;
                    end
                endcase
            end
        end
    end

    // Clock line falls back low after each port write, so every clocked
    // write of a load gives exactly one rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_sclk <= 1'b0;
        end else begin
            prev_sclk <= port_wr && sclk_bit;
        end
    end

    // Serial frame sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= DTL_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 10'h000;
        end else if (port_wr) begin
            case (state)
                DTL_IDLE: begin
                    if (wbyte == `DTL_ENABLE_CODE) begin
                        state <= DTL_SHIFT;
                        bit_cnt <= 4'h0;
                    end
                end
                DTL_SHIFT: begin
                    if (sclk_rise) begin
                        // Address MSB first, then value D7..D0
                        shreg <= {shreg[8:0], sdata_bit};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `DTL_FRAME_BITS - 4'h1) begin
                            state <= DTL_WAIT_END;
                        end
                    end else if (!sclk_bit && !sdata_bit) begin
                        // Early end byte abandons the frame
                        state <= DTL_IDLE;
                    end
                end
                DTL_WAIT_END: begin
                    // End byte may carry clock high; data low closes it
                    if (!sdata_bit) begin
                        state <= DTL_IDLE;
                    end
                end
                default: begin
                    state <= DTL_IDLE;
                end
            endcase
        end
    end

    // Pot registers; only gain trims exist, no offset pot
    generate
        for (genvar p = 0; p < NUM_POTS; p++) begin : g_pot
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    trim[p] <= `DTL_TRIM_RESET;
                end else if (port_wr && state == DTL_WAIT_END &&
                        !sdata_bit && shreg[9:8] == 2'(p)) begin
                    trim[p] <= shreg[7:0];
                end
            end
            assign trim_gain_o[p] = trim[p];
        end
    endgenerate

    // Clear strobes, one cycle each; global bit fans out to all
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_o <= '0;
            config_default_o <= 1'b0;
        end else begin
            clear_o.sample_queue_clear <= rst_wr &&
                (wbyte[`DTL_BIT_FIFO_CLR] ||
                 wbyte[`DTL_BIT_GLOBAL]);
            clear_o.parallel_port_clear <= rst_wr &&
                (wbyte[`DTL_BIT_DIO_CLR] ||
                 wbyte[`DTL_BIT_GLOBAL]);
            clear_o.analog_out_zero <= rst_wr &&
                (wbyte[`DTL_BIT_DAC_ZERO] ||
                 wbyte[`DTL_BIT_GLOBAL]);
            clear_o.global_clear <= rst_wr &&
                wbyte[`DTL_BIT_GLOBAL];
            config_default_o <= rst_wr &&
                wbyte[`DTL_BIT_GLOBAL];
        end
    end

    // Assertions
    ack_answer_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req |=> ack_o)
        else $error("request not acknowledged");

    ack_pulse_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    model_read_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !we_i && !adr_i[7] && idx == `DTL_IDX_MODEL)
        |=> dat_o[7:0] == `DTL_MODEL_VALUE && dat_o[31:8] == 24'h0)
        else $error("model register read wrong");

    unused_read_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (req && !we_i && idx >= `DTL_IDX_UNUSED_LO &&
         idx <= `DTL_IDX_UNUSED_HI) |=> dat_o == 32'h0)
        else $error("unused offset read nonzero");

    unused_write_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && idx >= `DTL_IDX_UNUSED_LO &&
         idx <= `DTL_IDX_UNUSED_HI)
        |=> state == $past(state) && clear_o == '0 && !config_default_o)
        else $error("unused offset write had an effect");

    reset_quiet_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rst_wr && !wbyte[`DTL_BIT_FIFO_CLR] && !wbyte[`DTL_BIT_DIO_CLR] &&
         !wbyte[`DTL_BIT_DAC_ZERO] && !wbyte[`DTL_BIT_GLOBAL])
        |=> clear_o == '0 && !config_default_o)
        else $error("zero bits triggered a clear");

    fifo_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rst_wr && wbyte[`DTL_BIT_FIFO_CLR])
        |=> clear_o.sample_queue_clear)
        else $error("fifo clear missing");

    dio_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(clear_o.parallel_port_clear) |->
        $past(rst_wr) && ($past(wbyte[`DTL_BIT_DIO_CLR]) ||
        $past(wbyte[`DTL_BIT_GLOBAL])))
        else $error("dio clear without cause");

    dac_zero_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rst_wr && wbyte[`DTL_BIT_DAC_ZERO])
        |=> clear_o.analog_out_zero)
        else $error("dac zero missing");

    global_fan_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        clear_o.global_clear |-> clear_o.sample_queue_clear &&
        clear_o.parallel_port_clear && clear_o.analog_out_zero &&
        config_default_o)
        else $error("global clear incomplete");

    enable_start_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (port_wr && state == DTL_IDLE && wbyte == `DTL_ENABLE_CODE)
        |=> state == DTL_SHIFT && bit_cnt == 4'h0)
        else $error("enable code not accepted");

    idle_ignore_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (port_wr && state == DTL_IDLE && wbyte != `DTL_ENABLE_CODE)
        |=> state == DTL_IDLE)
        else $error("frame started without enable code");

    shift_edge_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state == DTL_SHIFT && sclk_rise)
        |=> shreg[0] == $past(sdata_bit))
        else $error("data bit not captured on clock rise");

    frame_len_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state == DTL_SHIFT && sclk_rise &&
         bit_cnt == `DTL_FRAME_BITS - 4'h1) |=> state == DTL_WAIT_END)
        else $error("frame did not close after ten bits");

    latch_end_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (port_wr && state == DTL_WAIT_END && !sdata_bit &&
         shreg[9:8] == 2'b01) |=> trim[1] == $past(shreg[7:0]) &&
        state == DTL_IDLE)
        else $error("end write did not latch pot 1");

    latch_pot0_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (port_wr && state == DTL_WAIT_END && !sdata_bit &&
         shreg[9:8] == 2'b00) |=> trim[0] == $past(shreg[7:0]) &&
        state == DTL_IDLE)
        else $error("end write did not latch pot 0");

    trim_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(port_wr && state == DTL_WAIT_END)
        |=> trim[0] == $past(trim[0]) && trim[1] == $past(trim[1]))
        else $error("trim changed outside an end write");

endmodule

// ==== tb/dtl_pot_model.sv ====
// Purpose: Behavioural model of the two gain trim potentiometers
// Assumes: Wiper positions follow the registered trim outputs
// Notes: One clock of lag, as a real pot latch would add
`timescale 1ns/1ps
module dtl_pot_model (
    // Clock
    input wire logic clk_i,
    // From the loader
    input wire dtl_pkg::dtl_trim_t trim_i [2],
    // Wiper positions
    output dtl_pkg::dtl_trim_t wiper_o [2]
);
    import dtl_pkg::*;
    // Gain pots only, index 0 for DAC0 and 1 for DAC1
    always_ff @(posedge clk_i) begin
        wiper_o <= trim_i;
    end
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the trim loader and reset registers
// Assumes: Classic Wishbone, registered ack and clear pulses
// Notes: Random trims come from a fixed xorshift seed
`timescale 1ns/1ps
module tb_top;
    import dtl_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc_i = 0;
    logic stb_i = 0;
    logic we_i = 0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o, rd, r;
    logic ack_o, config_default_o;
    logic [4:0] seen_clr;
    logic [7:0] ua;
    logic [4:0] ec;
    logic [3:0] sel = 4'hF;
    dtl_trim_t trim_gain_o [2];
    dtl_trim_t wiper [2];
    dtl_trim_t pot [2];
    dtl_clear_s clear_o;
    logic [7:0] rb [7] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h00, 8'hFF, 8'hE2};
    logic [31:0] seed = 32'd71;
    int num_errors = 0;
    int checks = 0;
    always #50 clk_i = ~clk_i;
    dtl_trim_regs u_dtl_trim_regs (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .trim_gain_o(trim_gain_o), .clear_o(clear_o),
        .config_default_o(config_default_o));
    dtl_pot_model u_dtl_pot_model (.clk_i(clk_i), .trim_i(trim_gain_o),
        .wiper_o(wiper));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [4:0] exp_clr(logic [7:0] d);
        return {d[0] | d[4], d[2] | d[4], d[3] | d[4], d[4], d[4]};
    endfunction
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wb(logic w, logic [7:0] a, logic [7:0] d);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        sel_i <= sel;
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        seen_clr = {clear_o, config_default_o};
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask
    // One port write per bit: data on bit 7, clock bit set
    task automatic sbit(logic b);
        wb(1, 8'h68, {b, 7'h01});
    endtask
    task automatic load(logic [1:0] a, logic [7:0] v);
        wb(1, 8'h68, 8'h80);
        for (int i = 1; i >= 0; i--) sbit(a[i]);
        for (int i = 7; i >= 0; i--) sbit(v[i]);
        wb(1, 8'h68, 8'h00);
        if (a < 2) pot[a[0]] = v;
        repeat (2) @(posedge clk_i);
        chk("wiper0", {24'h0, wiper[0]}, {24'h0, pot[0]});
        chk("wiper1", {24'h0, wiper[1]}, {24'h0, pot[1]});
        wb(0, 8'h40, 8'h00);
        chk("readback0", rd, {24'h0, pot[0]});
        wb(0, 8'h44, 8'h00);
        chk("readback1", rd, {24'h0, pot[1]});
    endtask
    task automatic complete_run();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk("trim0 reset", {24'h0, trim_gain_o[0]}, 32'h80);
        pot[0] = 8'h80;
        pot[1] = 8'h80;
        wb(0, 8'h7C, 8'h00);
        chk("model", rd, 32'h01);
        ua = 8'h70;
        for (int i = 0; i < 3; i++) begin
            r = xs();
            wb(1, ua, r[7:0]);
            wb(0, ua, 8'h00);
            chk("unused", rd, 32'h0);
            ua += 8'h04;
        end
        load(2'b01, 8'h4F);
        load(2'b00, 8'h00);
        load(2'b00, 8'hFF);
        load(2'b11, 8'h5A);
        repeat (6) begin
            r = xs();
            wb(1, 8'h68, r[15:8] | 8'h01);
            load(r[9:8], r[7:0]);
        end
        foreach (rb[i]) begin
            wb(1, 8'h6C, rb[i]);
            ec = exp_clr(rb[i]);
            chk("fifo clear", seen_clr[4], ec[4]);
            chk("dio clear", seen_clr[3], ec[3]);
            chk("dac zero", seen_clr[2], ec[2]);
            chk("global", seen_clr[1:0], ec[1:0]);
        end
        sel = 4'hE;
        wb(1, 8'h6C, 8'h1F);
        sel = 4'hF;
        chk("lane off", seen_clr, 32'h0);
        wb(1, 8'hEC, 8'h1F);
        chk("high adr", seen_clr, 32'h0);
        // Second reset in mid-run must bring trims back to mid scale
        rst_i <= 1;
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        pot[0] = 8'h80;
        pot[1] = 8'h80;
        wb(0, 8'h44, 8'h00);
        chk("trim1 reset", rd, {24'h0, pot[1]});
        load(2'b00, 8'h3C);
        complete_run();
    end
    // Whole run needs under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
endmodule
